// ### hdl/scu_capture_front_end.sv
// Notes on behaviour
// - framing from sync pins or from embedded codes, chosen by a control bit.
// - frame and line sync active levels are programmable.
// - pixel bus is 12 bits; color uses 8-bit samples, gray up to 12.
// - frame start and frame completion events are raised.
// - embedded framing raises an event for every start and end code.
// - color streams in 4:2:2, 8:8:8 or 5:6:5 are accepted as byte streams.
// - color goes to preview always, to codec only while codec enable set.
// - gray pixels with sync framing are stored raw, one or two per word by packing bit; with embedded framing, four bytes per word.
// - codec path is unavailable in gray mode.
// - frame counter captures every frame or one of every N, N 2 to 8.
// - sync framing samples after blank lines, then a pixel clock delay.
// - start code FF000080 marks the head of video data.
// - end code FF00009D marks the tail of video data.
// - only data between the codes is captured; blanking is dropped.
// - embedded framing uses 8 data bits; sync pins unused there.
// - device drives the master clock; sensor returns the pixel clock.
// - data is formatted into words and held before leaving the block.
// - system clock and pixel clock are separate; system clock is faster.
// - gray pixel left-justified in a half word, low half zero if single.
`timescale 1ns/10ps
`default_nettype none

module scu_capture_front_end
  import scu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sensor_pixel_clock_in,
  input wire logic [11:0] sensor_pixel_bus,
  input wire logic frame_sync_in,
  input wire logic line_sync_in,
  output logic sensor_master_clock_out,
  output logic [31:0] preview_data,
  output logic preview_valid,
  output logic [31:0] codec_data,
  output logic codec_valid,
  output logic evt_frame_start,
  output logic evt_frame_done,
  output logic evt_start_code,
  output logic evt_end_code
);

  typedef struct packed {
    logic [SCU_SY_W-1:0] sync_a;
    logic [SCU_SY_W-1:0] sync_b;
    logic pck_prev;
    logic fs_prev;
    logic ls_prev;
    logic [31:0] ctrl_one;
    logic [31:0] ctrl_two;
    logic [31:0] rdata;
    logic [7:0] mck_cnt;
    logic mck;
    logic in_frame;
    logic capture;
    logic [2:0] skip_cnt;
    logic [7:0] blank_cnt;
    logic [7:0] dly_cnt;
    logic line_on;
    logic [31:0] code_sh;
    logic emb_active;
    logic [2:0] code_skip;
    logic [15:0] since_eav;
    logic [15:0] since_sav;
    logic [15:0] line_period;
    logic [31:0] acc;
    logic [1:0] acc_n;
    logic [31:0] prev_word;
    logic prev_ok;
    logic [31:0] codec_word;
    logic codec_ok;
    logic ev_fs;
    logic ev_fd;
    logic ev_sav;
    logic ev_eav;
    logic [15:0] frame_cnt;
  } scu_state_t;

  scu_state_t st;
  scu_state_t next_st;

  logic pix_edge;
  logic fs_act;
  logic ls_act;
  logic push;
  logic [11:0] push_px;
  logic word_done;
  logic [31:0] word;
  logic frame_begin;
  logic [7:0] new_byte;

  function automatic logic active_level(input logic raw, input logic low_active);
    active_level = raw ^ low_active;
  endfunction

  always_comb
  begin
    pix_edge = 1'b0;
    fs_act = 1'b0;
    ls_act = 1'b0;
    push = 1'b0;
    push_px = 12'h000;
    word_done = 1'b0;
    word = 32'h0000_0000;
    frame_begin = 1'b0;
    new_byte = 8'h00;
    next_st = st;
    next_st.sync_a = {sensor_pixel_clock_in, frame_sync_in, line_sync_in, sensor_pixel_bus};
    next_st.sync_b = st.sync_a;
    next_st.pck_prev = st.sync_b[SCU_SY_PCK];
    next_st.ev_fs = 1'b0;
    next_st.ev_fd = 1'b0;
    next_st.ev_sav = 1'b0;
    next_st.ev_eav = 1'b0;
    next_st.prev_ok = 1'b0;
    next_st.codec_ok = 1'b0;
    next_st.rdata = 32'h0000_0000;

    // register port
    if (reg_wr)
    begin
      case (reg_addr)
        SCU_OFS_CTRL_ONE: next_st.ctrl_one = reg_wdata & SCU_C1_MASK;
        SCU_OFS_CTRL_TWO: next_st.ctrl_two = reg_wdata & SCU_C2_MASK;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        SCU_OFS_CTRL_ONE: next_st.rdata = st.ctrl_one;
        SCU_OFS_CTRL_TWO: next_st.rdata = st.ctrl_two;
        SCU_OFS_STATUS:
        begin
          next_st.rdata[SCU_ST_IN_FRAME] = st.in_frame;
          next_st.rdata[SCU_ST_LINE_ON] = st.line_on | st.emb_active;
          next_st.rdata[SCU_ST_CAPTURE] = st.capture;
          next_st.rdata[SCU_ST_FCNT_LSB +: 16] = st.frame_cnt;
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // master clock divided from the system clock
    if (st.mck_cnt >= st.ctrl_two[SCU_C2_MCKDIV_LSB +: 8])
    begin
      next_st.mck_cnt = 8'h00;
      next_st.mck = ~st.mck;
    end
    else
      next_st.mck_cnt = st.mck_cnt + 8'h01;

    // pixel clock edge found by sampling on the faster clock
    if (st.ctrl_one[SCU_C1_PCK_FALL])
      pix_edge = st.pck_prev & ~st.sync_b[SCU_SY_PCK];
    else
      pix_edge = ~st.pck_prev & st.sync_b[SCU_SY_PCK];
    fs_act = active_level(st.sync_b[SCU_SY_FS], st.ctrl_one[SCU_C1_FSYNC_LOW]);
    ls_act = active_level(st.sync_b[SCU_SY_LS], st.ctrl_one[SCU_C1_LSYNC_LOW]);
    // embedded codes ride on the low 8 data bits
    new_byte = st.sync_b[7:0];

    if (!st.ctrl_one[SCU_C1_ENABLE])
    begin
      next_st.in_frame = 1'b0;
      next_st.capture = 1'b0;
      next_st.skip_cnt = 3'h0;
      next_st.line_on = 1'b0;
      next_st.emb_active = 1'b0;
      next_st.code_skip = 3'h0;
      next_st.line_period = 16'h0000;
      next_st.acc_n = 2'h0;
    end
    else if (pix_edge && st.ctrl_one[SCU_C1_EMBEDDED])
    begin
      next_st.code_sh = {st.code_sh[23:0], new_byte};
      if (st.since_eav != 16'hFFFF)
        next_st.since_eav = st.since_eav + 16'h0001;
      if (st.since_sav != 16'hFFFF)
        next_st.since_sav = st.since_sav + 16'h0001;
      // emit only bytes after the start code
      if (st.emb_active && st.capture)
      begin
        if (st.code_skip != 3'h0)
          next_st.code_skip = st.code_skip - 3'h1;
        else
        begin
          push = 1'b1;
          push_px = {4'h0, st.code_sh[31:24]};
        end
      end
      if ({st.code_sh[23:0], new_byte} == SCU_CODE_SAV)
      begin
        next_st.ev_sav = 1'b1;
        next_st.emb_active = 1'b1;
        next_st.code_skip = SCU_CODE_BYTES;
        next_st.since_sav = 16'h0000;
        next_st.line_period = st.since_sav;
        // a long gap since the last end code means new frame
        frame_begin = (st.line_period == 16'h0000) || (st.since_eav > st.line_period);
      end
      if ({st.code_sh[23:0], new_byte} == SCU_CODE_EAV)
      begin
        next_st.ev_eav = 1'b1;
        next_st.emb_active = 1'b0;
        next_st.since_eav = 16'h0000;
      end
    end
    else if (pix_edge)
    begin
      next_st.fs_prev = fs_act;
      next_st.ls_prev = ls_act;
      frame_begin = fs_act && !st.fs_prev;
      if (!fs_act && st.fs_prev)
      begin
        if (st.in_frame && st.capture)
          next_st.ev_fd = 1'b1;
        next_st.in_frame = 1'b0;
        next_st.line_on = 1'b0;
      end
      // skip blank lines, then delay pixels
      if (st.in_frame && ls_act && !st.ls_prev)
      begin
        next_st.dly_cnt = 8'h00;
        if (st.blank_cnt < st.ctrl_one[SCU_C1_VBLANK_LSB +: 8])
          next_st.blank_cnt = st.blank_cnt + 8'h01;
        else
          next_st.line_on = 1'b1;
      end
      else if (!ls_act)
        next_st.line_on = 1'b0;
      else if (st.line_on && st.in_frame)
      begin
        if (st.dly_cnt < st.ctrl_one[SCU_C1_LDELAY_LSB +: 8])
          next_st.dly_cnt = st.dly_cnt + 8'h01;
        else if (st.capture)
        begin
          push = 1'b1;
          push_px = st.sync_b[11:0];
        end
      end
    end

    // one frame in every skip+1 is captured
    if (frame_begin)
    begin
      // frame completion at the next frame boundary
      if (st.ctrl_one[SCU_C1_EMBEDDED] && st.in_frame && st.capture)
        next_st.ev_fd = 1'b1;
      next_st.in_frame = 1'b1;
      next_st.blank_cnt = 8'h00;
      next_st.line_on = 1'b0;
      next_st.acc_n = 2'h0;
      next_st.capture = (st.skip_cnt == 3'h0);
      if (st.skip_cnt >= st.ctrl_one[SCU_C1_SKIP_LSB +: 3])
        next_st.skip_cnt = 3'h0;
      else
        next_st.skip_cnt = st.skip_cnt + 3'h1;
      if (st.skip_cnt == 3'h0)
      begin
        next_st.ev_fs = 1'b1;
        next_st.frame_cnt = st.frame_cnt + 16'h0001;
        if (st.ctrl_one[SCU_C1_EMBEDDED])
          next_st.code_skip = SCU_CODE_BYTES;
      end
      else
        next_st.emb_active = st.emb_active & st.ctrl_one[SCU_C1_EMBEDDED];
    end

    // words are assembled and held here
    if (push)
    begin
      if (st.ctrl_one[SCU_C1_GRAY] && !st.ctrl_one[SCU_C1_EMBEDDED])
      begin
        if (st.ctrl_two[SCU_C2_GRAY_PACK])
        begin
          word_done = 1'b1;
          word = {push_px, 4'h0, 16'h0000};
        end
        else if (st.acc_n == 2'h0)
        begin
          next_st.acc = {push_px, 4'h0, 16'h0000};
          next_st.acc_n = 2'h1;
        end
        else
        begin
          word_done = 1'b1;
          word = {st.acc[31:16], push_px, 4'h0};
          next_st.acc_n = 2'h0;
        end
      end
      else
      begin
        // any color format packs as four bytes, byte 0 on top
        next_st.acc = {st.acc[23:0], push_px[7:0]};
        next_st.acc_n = st.acc_n + 2'h1;
        if (st.acc_n == 2'h3)
        begin
          word_done = 1'b1;
          word = {st.acc[23:0], push_px[7:0]};
        end
      end
    end

    if (word_done)
    begin
      next_st.prev_word = word;
      next_st.prev_ok = 1'b1;
      if (st.ctrl_one[SCU_C1_CODEC_ON] && !st.ctrl_one[SCU_C1_GRAY])
      begin
        next_st.codec_word = word;
        next_st.codec_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.ctrl_one <= SCU_C1_RESET;
      st.ctrl_two <= SCU_C2_RESET;
    end
    else
      st <= next_st;
  end

  assign reg_rdata = st.rdata;
  assign sensor_master_clock_out = st.mck;
  assign preview_data = st.prev_word;
  assign preview_valid = st.prev_ok;
  assign codec_data = st.codec_word;
  assign codec_valid = st.codec_ok;
  assign evt_frame_start = st.ev_fs;
  assign evt_frame_done = st.ev_fd;
  assign evt_start_code = st.ev_sav;
  assign evt_end_code = st.ev_eav;

endmodule

`default_nettype wire

// ### hdl/scu_pkg.sv
package scu_pkg;

  // register byte offsets
  localparam logic [7:0] SCU_OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] SCU_OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] SCU_OFS_STATUS = 8'h08;

  // capture_control_one fields
  localparam int SCU_C1_ENABLE = 0;
  localparam int SCU_C1_EMBEDDED = 1;
  localparam int SCU_C1_FSYNC_LOW = 2;
  localparam int SCU_C1_LSYNC_LOW = 3;
  localparam int SCU_C1_PCK_FALL = 4;
  localparam int SCU_C1_GRAY = 5;
  localparam int SCU_C1_CODEC_ON = 6;
  localparam int SCU_C1_SKIP_LSB = 8;
  localparam int SCU_C1_LDELAY_LSB = 16;
  localparam int SCU_C1_VBLANK_LSB = 24;
  localparam logic [31:0] SCU_C1_RESET = 32'h0000_0000;
  localparam logic [31:0] SCU_C1_MASK = 32'hFFFF_077F;

  // capture_control_two fields
  localparam int SCU_C2_GRAY_PACK = 0;
  localparam int SCU_C2_FMT_LSB = 2;
  localparam int SCU_C2_MCKDIV_LSB = 8;
  localparam logic [31:0] SCU_C2_RESET = 32'h0000_0000;
  localparam logic [31:0] SCU_C2_MASK = 32'h0000_FF0D;

  // status fields
  localparam int SCU_ST_IN_FRAME = 0;
  localparam int SCU_ST_LINE_ON = 1;
  localparam int SCU_ST_CAPTURE = 2;
  localparam int SCU_ST_FCNT_LSB = 16;

  // color stream formats held in capture_control_two
  localparam logic [1:0] SCU_FMT_YCC422 = 2'h0;
  localparam logic [1:0] SCU_FMT_RGB888 = 2'h1;
  localparam logic [1:0] SCU_FMT_RGB565 = 2'h2;

  // embedded timing reference codes
  localparam logic [31:0] SCU_CODE_SAV = 32'hFF00_0080;
  localparam logic [31:0] SCU_CODE_EAV = 32'hFF00_009D;
  localparam logic [2:0] SCU_CODE_BYTES = 3'h4;

  // synchroniser bit positions
  localparam int SCU_SY_PCK = 14;
  localparam int SCU_SY_FS = 13;
  localparam int SCU_SY_LS = 12;
  localparam int SCU_SY_W = 15;

endpackage

// ### sim/scu_capture_front_end_chk.sv
`timescale 1ns/10ps
`default_nettype none
module scu_capture_front_end_chk
  import scu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic sensor_master_clock_out,
  input wire logic [31:0] preview_data,
  input wire logic preview_valid,
  input wire logic [31:0] codec_data,
  input wire logic codec_valid,
  input wire logic evt_frame_start,
  input wire logic evt_start_code,
  input wire logic evt_end_code
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence c2_wr;
    reg_wr && reg_addr == SCU_OFS_CTRL_TWO;
  endsequence
  sequence c2_rd;
    reg_rd && reg_addr == SCU_OFS_CTRL_TWO;
  endsequence
  sequence mck_edge;
    ##[1:512] $changed(sensor_master_clock_out);
  endsequence
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  rd_unmap_a: assert property (reg_rd && reg_addr > SCU_OFS_STATUS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  wr_rd_a: assert property (c2_wr ##1 !reg_wr ##1 c2_rd |=> reg_rdata == ($past(reg_wdata, 3) & SCU_C2_MASK))
    else $error("control two readback wrong");
  codec_copy_a: assert property (codec_valid |-> preview_valid && codec_data == preview_data)
    else $error("codec word without preview word");
  word_pulse_a: assert property (preview_valid |=> !preview_valid [*3])
    else $error("preview valid too close");
  data_hold_a: assert property (!preview_valid |-> $stable(preview_data))
    else $error("preview data moved without valid");
  evt_single_a: assert property (evt_frame_start |=> !evt_frame_start)
    else $error("frame start longer than a pulse");
  code_gap_a: assert property (evt_start_code |=> !evt_end_code [*8])
    else $error("end code too soon after start code");
  mck_run_a: assert property (1'b1 |-> mck_edge)
    else $error("master clock stopped");
endmodule
bind scu_capture_front_end scu_capture_front_end_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sensor_master_clock_out(sensor_master_clock_out), .preview_data(preview_data),
  .preview_valid(preview_valid), .codec_data(codec_data), .codec_valid(codec_valid),
  .evt_frame_start(evt_frame_start), .evt_start_code(evt_start_code), .evt_end_code(evt_end_code));
`default_nettype wire

// ### sim/scu_sensor_model.sv
`timescale 1ns/10ps
`default_nettype none
module scu_sensor_model
  import scu_pkg::*;
(
  output var logic pck,
  output var logic [11:0] bus,
  output logic fs,
  output logic ls
);
  logic fs_low = 1'b0;
  logic ls_low = 1'b0;
  logic fa = 1'b0;
  logic la = 1'b0;
  assign fs = fa ^ fs_low;
  assign ls = la ^ ls_low;
  initial
  begin
    pck = 1'b0;
    bus = 12'h000;
  end
  task automatic tick(input logic [11:0] d);
    bus = d;
    #60 pck = 1'b1;
    #80 pck = 1'b0;
    #60;
  endtask
  task automatic code(input logic [31:0] c);
    for (int i = 3; i >= 0; i--)
      tick({4'h0, c[8*i +: 8]});
  endtask
  task automatic frame(input logic emb, input logic [11:0] px[$]);
    if (emb)
    begin
      repeat (4) tick(12'h010);
      code(SCU_CODE_SAV);
    end
    else
    begin
      fa = 1'b1;
      tick(~bus);
      la = 1'b1;
      tick(~bus);
    end
    foreach (px[i]) tick(px[i]);
    if (emb)
      code(SCU_CODE_EAV);
    else
    begin
      la = 1'b0;
      tick(~bus);
      fa = 1'b0;
      tick(~bus);
    end
    bus = ~bus;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_scu_capture_front_end.sv
`timescale 1ns/10ps
`default_nettype none
module tb_scu_capture_front_end
  import scu_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, preview_data, codec_data, rv;
  logic mck, pv, cv, efs, efd, esc, eec;
  wire logic pck, fs, ls;
  wire logic [11:0] bus;
  int errors = 0;
  int checks_done = 0;
  int n_fs = 0, n_fd = 0, n_sc = 0, n_ec = 0;
  logic [31:0] pq[$], cq[$], eq[$];
  always #12.5 clk_sys = ~clk_sys;
  scu_capture_front_end dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sensor_pixel_clock_in(pck),
    .sensor_pixel_bus(bus), .frame_sync_in(fs), .line_sync_in(ls), .sensor_master_clock_out(mck),
    .preview_data(preview_data), .preview_valid(pv), .codec_data(codec_data), .codec_valid(cv),
    .evt_frame_start(efs), .evt_frame_done(efd), .evt_start_code(esc), .evt_end_code(eec));
  scu_sensor_model sen_u (.pck(pck), .bus(bus), .fs(fs), .ls(ls));
  always @(negedge clk_sys)
  begin
    if (pv === 1'b1) pq.push_back(preview_data);
    if (cv === 1'b1) cq.push_back(codec_data);
    n_fs += int'(efs === 1'b1);
    n_fd += int'(efd === 1'b1);
    n_sc += int'(esc === 1'b1);
    n_ec += int'(eec === 1'b1);
  end
  task automatic conclude;
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata, e);
  endtask
  function automatic logic [31:0] word(input logic g, input logic p, input logic [11:0] q[$], input int i);
    if (!g) return {q[i][7:0], q[i+1][7:0], q[i+2][7:0], q[i+3][7:0]};
    if (p) return {q[i], 4'h0, 16'h0000};
    return {q[i], 4'h0, q[i+1], 4'h0};
  endfunction
  task automatic run(input logic [31:0] c1, input logic [31:0] c2, input int frames);
    logic [11:0] px[$];
    logic [11:0] v;
    logic g;
    int f0, d0, s0, e0;
    int sk;
    g = c1[SCU_C1_GRAY] & ~c1[SCU_C1_EMBEDDED];
    // blank lines drop the only line; delay drops leading pixels
    sk = (c1[SCU_C1_VBLANK_LSB +: 8] != 8'h00) ? 8 : int'(c1[SCU_C1_LDELAY_LSB +: 8]);
    f0 = n_fs;
    d0 = n_fd;
    s0 = n_sc;
    e0 = n_ec;
    wr(SCU_OFS_CTRL_ONE, 32'h0000_0000);
    sen_u.fs_low = c1[SCU_C1_FSYNC_LOW];
    sen_u.ls_low = c1[SCU_C1_LSYNC_LOW];
    wr(SCU_OFS_CTRL_TWO, c2);
    wr(SCU_OFS_CTRL_ONE, c1);
    pq = {};
    cq = {};
    eq = {};
    for (int i = 0; i < 8; i++)
    begin
      v = 12'($urandom);
      if (c1[SCU_C1_EMBEDDED]) v = (v & 12'hF7F) | 12'h001;
      px.push_back(v);
    end
    repeat (frames) sen_u.frame(c1[SCU_C1_EMBEDDED], px);
    repeat (40) @(posedge clk_sys);
    for (int i = sk; i < 8; i += (!g ? 4 : (c2[SCU_C2_GRAY_PACK] ? 1 : 2)))
      eq.push_back(word(g, c2[SCU_C2_GRAY_PACK], px, i));
    check(32'(pq.size()), 32'(eq.size()));
    foreach (eq[i]) if (i < pq.size()) check(pq[i], eq[i]);
    check(32'(cq.size()), (c1[SCU_C1_CODEC_ON] && !g) ? 32'(pq.size()) : 32'h0000_0000);
    foreach (cq[i]) if (i < eq.size()) check(cq[i], eq[i]);
    check(32'(n_fs - f0), 32'h0000_0001);
    if (c1[SCU_C1_EMBEDDED]) check(32'(n_sc - s0 + n_ec - e0), 32'h0000_0002);
    else check(32'(n_fd - d0), 32'h0000_0001);
  endtask
  initial
  begin
    #2_000_000;
    errors++;
    conclude;
  end
  initial
  begin
    void'($urandom(32'h16ba));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(SCU_OFS_CTRL_ONE, SCU_C1_RESET);
    rd(SCU_OFS_CTRL_TWO, SCU_C2_RESET);
    rd(8'h10, 32'h0000_0000);
    wr(SCU_OFS_STATUS, 32'hFFFF_FFFF);
    rd(SCU_OFS_STATUS, 32'h0000_0000);
    rv = $urandom;
    wr(SCU_OFS_CTRL_TWO, rv);
    rd(SCU_OFS_CTRL_TWO, rv & SCU_C2_MASK);
    for (int f = 0; f < 3; f++) run(32'h0000_0041, 32'(f) << SCU_C2_FMT_LSB, 1);
    run(32'h0000_004D, 32'h0000_0100, 1);
    run(32'h0000_0051, 32'h0000_0000, 1);
    run(32'h0004_0041, 32'h0000_0000, 1);
    run(32'h0100_0041, 32'h0000_0000, 1);
    run(32'h0000_0001, 32'h0000_0000, 1);
    run(32'h0000_0061, 32'h0000_0000, 1);
    run(32'h0000_0061, 32'h0000_0001, 1);
    run(32'h0000_0043, 32'h0000_0000, 1);
    run(32'h0000_0101, 32'h0000_0000, 2);
    run(32'h0000_0701, 32'h0000_0000, 8);
    conclude;
  end
endmodule
`default_nettype wire
